// file: inc/sercs_pkg.sv
// Package for serializer control and status: register map, field layout, encodings
package sercs_pkg;
  // Number of serializers and bus widths
  localparam int SER_COUNT = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register byte offsets of the local map, one aligned word each
  localparam logic [ADDR_W-1:0] TX_DMA_EVT_CTL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] SER_CTL_BASE_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] GLOBAL_CTL_OFS = 12'h020;
  localparam logic [ADDR_W-1:0] PIN_FUNC_OFS = 12'h024;
  localparam logic [ADDR_W-1:0] TX_BUF_BASE_OFS = 12'h040;
  localparam logic [ADDR_W-1:0] RX_BUF_BASE_OFS = 12'h050;
  localparam logic [ADDR_W-1:0] SER_STRIDE = 12'h004;
  // Serializer control field positions and widths
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int DRIVE_LSB = 2;
  localparam int DRIVE_W = 2;
  localparam int TXRDY_BIT = 4;
  localparam int RXRDY_BIT = 5;
  // Global control field position of the transmit serializer clear
  localparam int TX_SER_CLR_BIT = 10;
  // Transmit DMA event control field position
  localparam int TX_DMA_EN_BIT = 0;
  // Reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Serializer mode encodings
  localparam logic [1:0] MODE_INACTIVE = 2'h0;
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  // Pin drive mode encodings
  localparam logic [1:0] DRIVE_HIZ = 2'h0;
  localparam logic [1:0] DRIVE_LOW = 2'h2;
  localparam logic [1:0] DRIVE_HIGH = 2'h3;
  // Pin function value that hands the pin to the port
  localparam logic PIN_FUNC_PORT = 1'b0;
  // Data-pin owner state
  typedef enum logic [1:0] {SERCS_PIN_IDLE, SERCS_PIN_SLOT, SERCS_PIN_GPIO} sercs_pin_t;
endpackage : sercs_pkg

// file: hw/sercs_top.sv
// Serializer control and status registers with transmit DMA enable, on APB
`timescale 1ns/1ps
`default_nettype none
module sercs_top
  import sercs_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serializer datapath events, one bit per serializer
  input wire logic [SER_COUNT-1:0] rx_word_load,
  input wire logic [SER_COUNT-1:0] slot_start,
  input wire logic [SER_COUNT-1:0] slot_active,
  input wire logic [SER_COUNT-1:0] slot_tx_data,
  input wire logic [SER_COUNT-1:0] rx_word_data,
  // Data pins
  output logic [SER_COUNT-1:0] data_pin_out,
  output logic [SER_COUNT-1:0] data_pin_oe,
  // DMA, error and ready flag indications
  output logic tx_dma_request_enable,
  output logic [SER_COUNT-1:0] tx_dma_request,
  output logic [SER_COUNT-1:0] rx_overrun,
  output logic [SER_COUNT-1:0] tx_underrun,
  output logic [SER_COUNT-1:0] tx_ready_flag,
  output logic [SER_COUNT-1:0] rx_ready_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Everything the block remembers lives in this one record, so reset
  // and the clocked update cover every bit in one place.
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_dma_dis;
    logic dma_en;
    logic tx_ser_clr;
    logic [SER_COUNT-1:0] pin_func;
    logic [SER_COUNT-1:0][MODE_W-1:0] ser_mode;
    logic [SER_COUNT-1:0][DRIVE_W-1:0] drive_mode;
    logic [SER_COUNT-1:0] txrdy;
    logic [SER_COUNT-1:0] rxrdy;
    logic [SER_COUNT-1:0][DATA_W-1:0] rx_buf;
    logic [SER_COUNT-1:0] pin_out;
    logic [SER_COUNT-1:0] pin_oe;
    logic [SER_COUNT-1:0] dma_req;
    logic [SER_COUNT-1:0] ovr;
    logic [SER_COUNT-1:0] unr;
  } sercs_state_t;

  sercs_state_t st_r;
  sercs_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode
  // Walk: setup cycle, then the access cycle in which the transfer is taken.
  // pready stands high for the next cycle only and then drops by itself.
  // The !pready term keeps a held access phase from being taken twice.
  logic acc;
  logic wr;
  logic rd;
  assign acc = psel && penable && !st_r.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Register hits
  // Decoded once here so the read mux and every write share one decode;
  // an address outside the map hits nothing and earns an error response.
  logic hit_dma;
  logic hit_glb;
  logic hit_pfn;
  logic [SER_COUNT-1:0] hit_ctl;
  logic [SER_COUNT-1:0] hit_tbuf;
  logic [SER_COUNT-1:0] hit_rx_buffer;
  logic any_hit;

  // Serializer n sits one stride above serializer n-1
  always_comb begin
    hit_dma = (paddr == TX_DMA_EVT_CTL_OFS);
    hit_glb = (paddr == GLOBAL_CTL_OFS);
    hit_pfn = (paddr == PIN_FUNC_OFS);
    hit_ctl = '0;
    hit_tbuf = '0;
    hit_rx_buffer = '0;
    for (int i = 0; i < SER_COUNT; i++) begin
      hit_ctl[i] = (paddr == SER_CTL_BASE_OFS + ADDR_W'(i) * SER_STRIDE);
      hit_tbuf[i] = (paddr == TX_BUF_BASE_OFS + ADDR_W'(i) * SER_STRIDE);
      hit_rx_buffer[i] = (paddr == RX_BUF_BASE_OFS + ADDR_W'(i) * SER_STRIDE);
    end
    any_hit = hit_dma || hit_glb || hit_pfn || (|hit_ctl) || (|hit_tbuf) || (|hit_rx_buffer);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer strobes
  // Any bus master counts, a debugger included, so a debug peek at a
  // buffer moves the ready flags exactly as a normal access does.
  logic [SER_COUNT-1:0] tbuf_wr;
  logic [SER_COUNT-1:0] rx_buffer_rd;
  logic clr_rise_wr;
  assign tbuf_wr = hit_tbuf & {SER_COUNT{wr}};
  assign rx_buffer_rd = hit_rx_buffer & {SER_COUNT{rd}};
  // Clear bit written 0 to 1; taken from the write so the flag is not late
  assign clr_rise_wr = wr && hit_glb && pwdata[TX_SER_CLR_BIT] && !st_r.tx_ser_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux
  // Reserved bits and unmapped addresses read zero
  logic [DATA_W-1:0] rdat;
  always_comb begin
    rdat = ZERO_WORD;
    if (hit_dma) begin
      rdat[TX_DMA_EN_BIT] = st_r.tx_dma_dis; // Upper bits stay zero
    end
    if (hit_glb) begin
      rdat[TX_SER_CLR_BIT] = st_r.tx_ser_clr;
    end
    if (hit_pfn) begin
      rdat[SER_COUNT-1:0] = st_r.pin_func;
    end
    for (int i = 0; i < SER_COUNT; i++) begin
      if (hit_ctl[i]) begin
        rdat[MODE_LSB +: MODE_W] = st_r.ser_mode[i];
        rdat[DRIVE_LSB +: DRIVE_W] = st_r.drive_mode[i];
        rdat[TXRDY_BIT] = st_r.txrdy[i];
        rdat[RXRDY_BIT] = st_r.rxrdy[i]; // Bits above stay zero
      end
      if (hit_rx_buffer[i]) begin
        rdat = st_r.rx_buf[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    sercs_pin_t own;
    own = SERCS_PIN_IDLE;
    st_nxt = st_r;

    // Single wait state: answer one cycle into the access phase
    st_nxt.pready = acc;
    st_nxt.pslverr = 1'b0;
    if (acc) begin
      st_nxt.pslverr = !any_hit;
      // Writes return zero so stale read data never leaks
      st_nxt.prdata = pwrite ? ZERO_WORD : rdat;
    end

    // Register writes; only defined fields are stored
    if (wr && hit_dma) begin
      st_nxt.tx_dma_dis = pwdata[TX_DMA_EN_BIT]; // Software keeps this 0
    end
    // Enable kept in its own flop so the port comes straight from one
    st_nxt.dma_en = !st_nxt.tx_dma_dis;
    if (wr && hit_glb) begin
      st_nxt.tx_ser_clr = pwdata[TX_SER_CLR_BIT];
    end
    if (wr && hit_pfn) begin
      st_nxt.pin_func = pwdata[SER_COUNT-1:0];
    end
    // Reserved codes are stored and read back; the reserved mode code holds both ready flags clear and releases the pin
    for (int i = 0; i < SER_COUNT; i++) begin
      if (wr && hit_ctl[i]) begin
        st_nxt.ser_mode[i] = pwdata[MODE_LSB +: MODE_W];
        st_nxt.drive_mode[i] = pwdata[DRIVE_LSB +: DRIVE_W];
      end
    end

    // Receive ready: load sets, buffer read clears; set wins a tie
    for (int i = 0; i < SER_COUNT; i++) begin
      if (st_r.ser_mode[i] != MODE_RX) begin
        st_nxt.rxrdy[i] = 1'b0;
      end else if (rx_word_load[i]) begin
        st_nxt.rxrdy[i] = 1'b1;
        // Serial bit enters at the bottom of the buffer
        st_nxt.rx_buf[i] = {st_r.rx_buf[i][DATA_W-2:0], rx_word_data[i]};
      end else if (rx_buffer_rd[i]) begin
        st_nxt.rxrdy[i] = 1'b0;
      end
      // Overrun: slot starts with data still unread
      st_nxt.ovr[i] = slot_start[i] && st_r.rxrdy[i] && !rx_buffer_rd[i];
    end

    // Transmit ready: documented clears win, except the 0-to-1 clear write
    for (int i = 0; i < SER_COUNT; i++) begin
      if (st_r.ser_mode[i] != MODE_TX) begin
        st_nxt.txrdy[i] = 1'b0;
      end else if (clr_rise_wr) begin
        st_nxt.txrdy[i] = 1'b1;
      end else if (!st_r.tx_ser_clr) begin
        st_nxt.txrdy[i] = 1'b0;
      end else if (tbuf_wr[i]) begin
        st_nxt.txrdy[i] = 1'b0;
      end else if (slot_start[i]) begin
        st_nxt.txrdy[i] = 1'b1; // Shift register took the word
      end
      // Underrun: slot starts with buffer still empty
      st_nxt.unr[i] = slot_start[i] && st_r.txrdy[i] && !tbuf_wr[i];
      // Request follows the flag as it will be registered
      st_nxt.dma_req[i] = !st_r.tx_dma_dis && st_nxt.txrdy[i];
    end

    // Data pin owner: port function first, then mode and slot activity
    for (int i = 0; i < SER_COUNT; i++) begin
      if (st_r.pin_func[i] != PIN_FUNC_PORT) begin
        own = SERCS_PIN_GPIO; // Drive mode ignored off-port
      end else if (st_r.ser_mode[i] == MODE_TX && slot_active[i]) begin
        own = SERCS_PIN_SLOT;
      end else if (st_r.ser_mode[i] == MODE_TX || st_r.ser_mode[i] == MODE_INACTIVE) begin
        own = SERCS_PIN_IDLE; // Inactive slot or inactive serializer
      end else begin
        own = SERCS_PIN_GPIO; // Receiver and reserved code never drive
      end
      case (own)
        SERCS_PIN_SLOT: begin
          st_nxt.pin_out[i] = slot_tx_data[i];
          st_nxt.pin_oe[i] = 1'b1;
        end
        SERCS_PIN_IDLE: begin
          case (st_r.drive_mode[i])
            DRIVE_LOW: begin
              st_nxt.pin_out[i] = 1'b0;
              st_nxt.pin_oe[i] = 1'b1;
            end
            DRIVE_HIGH: begin
              st_nxt.pin_out[i] = 1'b1;
              st_nxt.pin_oe[i] = 1'b1;
            end
            default: begin
              // High impedance; reserved code treated the same
              st_nxt.pin_out[i] = 1'b0;
              st_nxt.pin_oe[i] = 1'b0;
            end
          endcase
        end
        default: begin
          // Released pin: value parked low so nothing toggles needlessly
          st_nxt.pin_out[i] = 1'b0;
          st_nxt.pin_oe[i] = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Reset loads constants only; the enable flop starts high because the
  // enable bit starts at 0, so requests are allowed from the first cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ser_mode <= {SER_COUNT{MODE_RESET}};
      st_r.drive_mode <= {SER_COUNT{DRIVE_RESET}};
      st_r.pin_func <= {SER_COUNT{PIN_FUNC_PORT}};
      st_r.dma_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  // Bus answer
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  // Pin value and enable, one cycle behind the slot signals
  assign data_pin_out = st_r.pin_out;
  assign data_pin_oe = st_r.pin_oe;
  // DMA, error pulses and flag copies
  assign tx_dma_request_enable = st_r.dma_en;
  assign tx_dma_request = st_r.dma_req;
  assign rx_overrun = st_r.ovr;
  assign tx_underrun = st_r.unr;
  assign tx_ready_flag = st_r.txrdy;
  assign rx_ready_flag = st_r.rxrdy;

endmodule : sercs_top
`default_nettype wire

// file: tb/sercs_chk.sv
// Port checker for the serializer control and status block
`timescale 1ns/1ps
`default_nettype none
module sercs_chk
  import sercs_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Serializer events and flags
  input wire logic [SER_COUNT-1:0] rx_word_load,
  input wire logic [SER_COUNT-1:0] slot_start,
  input wire logic tx_dma_request_enable,
  input wire logic [SER_COUNT-1:0] tx_dma_request,
  input wire logic [SER_COUNT-1:0] rx_overrun,
  input wire logic [SER_COUNT-1:0] tx_underrun,
  input wire logic [SER_COUNT-1:0] tx_ready_flag,
  input wire logic [SER_COUNT-1:0] rx_ready_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Access phase still waiting for its answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  AST_ANSWER: assert property (s_wait |=> pready)
    else $error("access not answered in one cycle");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_EXCL: assert property ((tx_ready_flag & rx_ready_flag) == '0)
    else $error("both ready flags set");
  AST_RX_CAUSE: assert property ((rx_ready_flag & ~$past(rx_ready_flag)
    & ~($past(rx_word_load) | $past(rx_word_load, 2) | $past(rx_word_load, 3))) == '0)
    else $error("receive ready rose without a word");
  AST_OVR: assert property ((rx_overrun & ~(($past(slot_start) | $past(slot_start, 2))
    & (rx_ready_flag | $past(rx_ready_flag) | $past(rx_ready_flag, 2)))) == '0)
    else $error("overrun without slot and full buffer");
  AST_UNR: assert property ((tx_underrun & ~(($past(slot_start) | $past(slot_start, 2))
    & (tx_ready_flag | $past(tx_ready_flag) | $past(tx_ready_flag, 2)))) == '0)
    else $error("underrun without slot and empty buffer");
  AST_DMA_EN: assert property (tx_dma_request_enable)
    else $error("dma enable dropped");
  AST_DMA_REQ: assert property ((tx_dma_request
    & ~(tx_ready_flag | $past(tx_ready_flag))) == '0)
    else $error("dma request without transmit ready");
endmodule : sercs_chk
bind sercs_top sercs_chk chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .rx_word_load,
  .slot_start, .tx_dma_request_enable, .tx_dma_request, .rx_overrun, .tx_underrun,
  .tx_ready_flag, .rx_ready_flag);
`default_nettype wire

// file: tb/sercs_codec.sv
// Behavioural converter model on the serializer side
`timescale 1ns/1ps
`default_nettype none
module sercs_codec
  import sercs_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Slot and word events toward the block
  output logic [SER_COUNT-1:0] rx_word_load,
  output logic [SER_COUNT-1:0] slot_start,
  output logic [SER_COUNT-1:0] slot_active,
  output logic [SER_COUNT-1:0] slot_tx_data,
  output logic [SER_COUNT-1:0] rx_word_data
);
  initial begin
    {rx_word_load, slot_start, slot_active, slot_tx_data, rx_word_data} = '0;
  end
  // Serial data never rests, so a stale bit cannot pass for a real one
  always @(posedge pclk) begin
    rx_word_data <= ~rx_word_data;
  end
  // One-cycle slot start or word load
  task automatic pulse(input bit slot, input int n);
    @(posedge pclk);
    if (slot) slot_start[n] <= 1'b1;
    else rx_word_load[n] <= 1'b1;
    @(posedge pclk);
    {slot_start, rx_word_load} <= '0;
  endtask : pulse
  // Slot activity and data bit, held until the next call
  task automatic level(input int n, input logic act, input logic b);
    @(posedge pclk);
    slot_active[n] <= act;
    slot_tx_data[n] <= b;
  endtask : level
endmodule : sercs_codec
`default_nettype wire

// file: tb/serializer_control_status_bench.sv
// Self-checking bench for the serializer control and status block
`timescale 1ns/1ps
`default_nettype none
module serializer_control_status_bench
  import sercs_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, q;
  logic tx_dma_request_enable;
  logic [SER_COUNT-1:0] rx_word_load, slot_start, slot_active, slot_tx_data, rx_word_data;
  logic [SER_COUNT-1:0] data_pin_out, data_pin_oe, tx_dma_request, rx_overrun, tx_underrun;
  logic [SER_COUNT-1:0] tx_ready_flag, rx_ready_flag, ovr_seen = '0, unr_seen = '0;
  logic [1:0] dm [3] = '{DRIVE_HIZ, DRIVE_LOW, DRIVE_HIGH};
  int mismatches = 0, checked = 0;
  sercs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_word_load, .slot_start, .slot_active, .slot_tx_data, .rx_word_data,
    .data_pin_out, .data_pin_oe, .tx_dma_request_enable, .tx_dma_request, .rx_overrun,
    .tx_underrun, .tx_ready_flag, .rx_ready_flag);
  sercs_codec codec (.pclk, .rx_word_load, .slot_start, .slot_active, .slot_tx_data,
    .rx_word_data);
  always #20 pclk = ~pclk;
  // Error pulses last one cycle, so keep them sticky
  always @(posedge pclk) begin
    ovr_seen <= ovr_seen | rx_overrun;
    unr_seen <= unr_seen | tx_underrun;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    apb(1'b0, a, '0);
    chk(q, x);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  // Watchdog well beyond the fewer than 200 cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    complete_run;
  end
  // Test sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TX_DMA_EVT_CTL_OFS, ZERO_WORD);
    apb(1'b1, TX_DMA_EVT_CTL_OFS, 32'hFFFF_FFFE);
    rd(TX_DMA_EVT_CTL_OFS, ZERO_WORD);
    chk(tx_dma_request_enable, 1'b1);
    apb(1'b1, SER_CTL_BASE_OFS, 32'hFFFF_FFFD);
    rd(SER_CTL_BASE_OFS, 32'h0000_000D);
    rd(12'hFFC, ZERO_WORD);
    chk(e, 1'b1);
    $display("test registers done");
    foreach (dm[i]) begin
      apb(1'b1, SER_CTL_BASE_OFS + 12'h008, {28'h0, dm[i], 2'h0});
      settle;
      chk({data_pin_oe[2], data_pin_out[2] & data_pin_oe[2]}, {dm[i][1], &dm[i]});
    end
    apb(1'b1, PIN_FUNC_OFS, 32'h0000_0004);
    settle;
    chk(data_pin_oe[2], 1'b0);
    $display("test pin drive done");
    apb(1'b1, GLOBAL_CTL_OFS, ZERO_WORD);
    apb(1'b1, GLOBAL_CTL_OFS, 32'h0000_0400);
    settle;
    chk(tx_ready_flag, 4'h1);
    chk(tx_dma_request, 4'h1);
    rd(SER_CTL_BASE_OFS, 32'h0000_001D);
    codec.level(0, 1'b1, 1'b0);
    settle;
    chk({data_pin_oe[0], data_pin_out[0]}, 2'b10);
    codec.level(0, 1'b0, 1'b0);
    settle;
    chk({data_pin_oe[0], data_pin_out[0]}, 2'b11);
    codec.pulse(1'b1, 0);
    settle;
    chk(unr_seen, 4'h1);
    apb(1'b1, TX_BUF_BASE_OFS, 32'h1234_5678);
    settle;
    chk(tx_ready_flag, 4'h0);
    chk(tx_dma_request, 4'h0);
    codec.pulse(1'b1, 0);
    apb(1'b1, GLOBAL_CTL_OFS, ZERO_WORD);
    settle;
    chk(tx_ready_flag, 4'h0);
    apb(1'b1, GLOBAL_CTL_OFS, 32'h0000_0400);
    apb(1'b1, SER_CTL_BASE_OFS, 32'h0000_0002);
    settle;
    chk(tx_ready_flag, 4'h0);
    $display("test transmit done");
    codec.pulse(1'b0, 0);
    settle;
    rd(SER_CTL_BASE_OFS, 32'h0000_0022);
    codec.pulse(1'b1, 0);
    settle;
    chk(ovr_seen, 4'h1);
    apb(1'b0, RX_BUF_BASE_OFS, '0);
    settle;
    chk(rx_ready_flag, 4'h0);
    codec.pulse(1'b0, 0);
    apb(1'b1, SER_CTL_BASE_OFS, ZERO_WORD);
    settle;
    chk(rx_ready_flag, 4'h0);
    $display("test receive done");
    complete_run;
  end
endmodule : serializer_control_status_bench
`default_nettype wire
